// >>> hdl/throttle_speed_direction_control.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "throttle_map.svh"

// How it works
// - Held speed key repeats until limit reached.
// - Fine key moves speed by one step.
// - Coarse key moves 5, 8 or 16.
// - Speed key or change shows speed view.
// - Reaching step zero returns to address view.
// - Enter toggles speed and address views.
// - Direction key at standstill inverts direction.
// - Direction key while moving stops immediately.
// - Next press reverses; indicator shows direction.
// - Emergency key toggles layout-wide stop.
// - Addresses 0 to 9999; zero means conventional.
// - Thirteen functions, each latching or momentary.
// - Step mode 14, 27, 28 or 128.
// - Top step in 128 mode is 126.
// - Address view shows four decimal digits.
// - Momentary follows key; latching toggles per press.
module throttle_speed_direction_control #(
   parameter int REPEAT_CYCLES = `REPEAT_MS * (`CLK_HZ / 1000)
) (
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic [4:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   output logic                        irq,
   input  wire logic                   key_fine_down,
   input  wire logic                   key_fine_up,
   input  wire logic                   key_coarse_down,
   input  wire logic                   key_coarse_up,
   input  wire logic                   key_enter,
   input  wire logic                   key_direction,
   input  wire logic                   key_emergency,
   input  wire logic [`FUNC_COUNT-1:0] key_function,
   output logic      [6:0]             speed_step,
   output logic                        forward,
   output logic                        show_speed,
   output logic                        immediate_stop,
   output logic                        emergency_stop,
   output logic      [13:0]            loco_address,
   output logic                        conventional_loco,
   output logic      [15:0]            address_digits,
   output throttle_pkg::step_mode_t    step_mode,
   output logic      [`FUNC_COUNT-1:0] function_active
);
   import throttle_pkg::*;

   if (REPEAT_CYCLES < 2) begin : g_bad
      $error("throttle: repeat period too short");
   end

   // -------------------------------------------------------------------------
   // Key conditioning
   // -------------------------------------------------------------------------
   key_if #(.N(`KEY_COUNT)) keys ();

   wire [`KEY_COUNT-1:0] key_raw = {key_function, key_emergency, key_direction,
                                    key_enter, key_coarse_up, key_coarse_down,
                                    key_fine_up, key_fine_down};

   key_conditioner #(
      .N_KEYS        (`KEY_COUNT),
      .N_REPEAT      (`KEY_REPEAT),
      .REPEAT_CYCLES (REPEAT_CYCLES)
   ) u_keys (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .key_raw (key_raw),
      .keys    (keys)
   );

   // -------------------------------------------------------------------------
   // Speed arithmetic
   // -------------------------------------------------------------------------
   wire       step_fdn = keys.step[`KEY_FINE_DN];
   wire       step_fup = keys.step[`KEY_FINE_UP];
   wire       step_cdn = keys.step[`KEY_COARSE_DN];
   wire       step_cup = keys.step[`KEY_COARSE_UP];
   wire       dir_key  = keys.press[`KEY_DIRECTION];
   wire       enter    = keys.press[`KEY_ENTER];
   wire       estop_key = keys.press[`KEY_EMERGENCY];

   wire [6:0] max_step = (step_mode == MODE_14) ? `MAX_STEP_14 :
                         (step_mode == MODE_27) ? `MAX_STEP_27 :
                         (step_mode == MODE_28) ? `MAX_STEP_28 :
                                                  `MAX_STEP_128;
   wire [6:0] coarse   = (step_mode == MODE_14)  ? `COARSE_14 :
                         (step_mode == MODE_128) ? `COARSE_128 :
                                                   `COARSE_28;

   // Down keys win over up keys when both fire together, as the safer choice.
   wire       go_down  = step_fdn | step_cdn;
   wire       go_up    = !go_down && (step_fup | step_cup);
   wire [6:0] delta    = (step_fdn || (!step_cdn && step_fup)) ? 7'h01 : coarse;
   wire       speed_ev = (go_down | go_up) && !emergency_stop;

   wire [7:0] sum      = {1'b0, speed_step} + {1'b0, delta};
   wire [6:0] up_val   = (sum > {1'b0, max_step}) ? max_step : sum[6:0];
   wire [6:0] dn_val   = (speed_step > delta) ? (speed_step - delta) : 7'h00;
   // Repeats simply keep stepping; saturation holds the limit while held.
   wire [6:0] stepped  = go_down ? dn_val : up_val;

   wire       moving   = (speed_step != 7'h00);
   wire       dir_stop = dir_key && moving;
   wire       dir_flip = dir_key && !moving;

   logic [6:0] next_speed;
   logic       next_view;
   always_comb begin
      next_speed = speed_step;
      next_view  = show_speed;
      if (estop_key && !emergency_stop) begin
         next_speed = 7'h00;
         next_view  = show_speed && !moving;
      end else if (dir_stop) begin
         next_speed = 7'h00;
         next_view  = 1'b0;
      end else if (speed_ev) begin
         next_speed = stepped;
         next_view  = !(moving && stepped == 7'h00);
      end else if (enter) begin
         next_view  = !show_speed;
      end
   end

   // -------------------------------------------------------------------------
   // Register bus decode
   // -------------------------------------------------------------------------
   bus_state_t bus_state;
   wire        req       = avs_read | avs_write;
   wire        wr_fire   = avs_write && (bus_state == BUS_ACK);
   wire [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire        wr_ctrl   = wr_fire && avs_address == `REG_CTRL;
   wire        wr_addr   = wr_fire && avs_address == `REG_ADDR;
   wire        wr_fmode  = wr_fire && avs_address == `REG_FUNC_MODE;
   wire        wr_status = wr_fire && avs_address == `REG_IRQ_STATUS;
   wire        wr_mask   = wr_fire && avs_address == `REG_IRQ_MASK;

   wire [31:0] addr_word = ({18'h0, loco_address} & ~be_mask) | (avs_writedata & be_mask);
   wire        addr_ok   = (addr_word[31:14] == 18'h0) && (addr_word[13:0] <= `ADDR_MAX);

   logic [`FUNC_COUNT-1:0] func_mode;
   logic [`IRQ_BITS-1:0]   irq_status;
   logic [`IRQ_BITS-1:0]   irq_mask;
   logic [15:0]            bcd;

   wire [31:0] speed_word = {21'h0, emergency_stop, show_speed, forward, 1'b0, speed_step};

   wire [31:0] rd_mux =
      (avs_address == `REG_CTRL)        ? {30'h0, step_mode} :
      (avs_address == `REG_ADDR)        ? {18'h0, loco_address} :
      (avs_address == `REG_ADDR_DIGITS) ? {16'h0, address_digits} :
      (avs_address == `REG_SPEED)       ? speed_word :
      (avs_address == `REG_FUNC_MODE)   ? {19'h0, func_mode} :
      (avs_address == `REG_FUNC_STATE)  ? {19'h0, function_active} :
      (avs_address == `REG_IRQ_STATUS)  ? {28'h0, irq_status} :
      (avs_address == `REG_IRQ_MASK)    ? {28'h0, irq_mask} :
                                          32'h0;

   // Every access takes one wait state: it is seen, answered the next edge.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bus_state       <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else begin
         unique case (bus_state)
            BUS_IDLE: begin
               if (req) begin
                  bus_state       <= BUS_ACK;
                  avs_waitrequest <= 1'b0;
                  avs_readdata    <= avs_read ? rd_mux : 32'h0;
               end
            end
            BUS_ACK: begin
               bus_state       <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   bin_to_bcd4 u_bcd (
      .bin (loco_address),
      .bcd (bcd)
   );

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         step_mode         <= MODE_28;
         loco_address      <= `ADDR_RESET;
         conventional_loco <= 1'b0;
         address_digits    <= 16'h0;
         func_mode         <= '0;
         irq_mask          <= '0;
      end else begin
         if (wr_ctrl && avs_byteenable[0]) begin
            step_mode <= step_mode_t'(avs_writedata[1:0]);
         end
         if (wr_addr && addr_ok) begin
            loco_address <= addr_word[13:0];
         end
         conventional_loco <= (loco_address == 14'h0);
         address_digits    <= bcd;
         if (wr_fmode) begin
            func_mode <= (func_mode & ~be_mask[`FUNC_COUNT-1:0]) |
                         (avs_writedata[`FUNC_COUNT-1:0] & be_mask[`FUNC_COUNT-1:0]);
         end
         if (wr_mask && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[`IRQ_BITS-1:0];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Locomotive state
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         speed_step     <= 7'h00;
         forward        <= 1'b1;
         show_speed     <= 1'b0;
         immediate_stop <= 1'b0;
         emergency_stop <= 1'b0;
      end else begin
         speed_step     <= next_speed;
         show_speed     <= next_view;
         immediate_stop <= dir_stop;
         if (dir_flip) begin
            forward <= !forward;
         end
         if (estop_key) begin
            emergency_stop <= !emergency_stop;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Decoder functions
   // -------------------------------------------------------------------------
   genvar f;
   for (f = 0; f < `FUNC_COUNT; f++) begin : g_func
      always_ff @(posedge sys_clk) begin
         if (!resetn) begin
            function_active[f] <= 1'b0;
         end else if (func_mode[f]) begin
            function_active[f] <= keys.level[`KEY_FUNC0 + f];
         end else if (keys.press[`KEY_FUNC0 + f]) begin
            function_active[f] <= !function_active[f];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------------
   wire [`IRQ_BITS-1:0] irq_event = {wr_addr && !addr_ok,
                                     estop_key,
                                     dir_flip,
                                     next_speed != speed_step};
   wire [`IRQ_BITS-1:0] irq_clear = wr_status && avs_byteenable[0] ?
                                    avs_writedata[`IRQ_BITS-1:0] : '0;

   // A new event beats a clear landing in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
         irq        <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
      end
   end

endmodule

// >>> hdl/throttle_map.svh
`ifndef THROTTLE_MAP_SVH
`define THROTTLE_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ            125000000
`define REPEAT_MS         100

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define REG_CTRL          5'h00
`define REG_ADDR          5'h04
`define REG_ADDR_DIGITS   5'h08
`define REG_SPEED         5'h0c
`define REG_FUNC_MODE     5'h10
`define REG_FUNC_STATE    5'h14
`define REG_IRQ_STATUS    5'h18
`define REG_IRQ_MASK      5'h1c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define SPEED_DIR_BIT     8
`define SPEED_VIEW_BIT    9
`define SPEED_ESTOP_BIT   10
`define IRQ_SPEED         0
`define IRQ_DIR           1
`define IRQ_ESTOP         2
`define IRQ_ADDR_REJECT   3
`define IRQ_BITS          4
`define ADDR_RESET        14'h0003
`define ADDR_MAX          14'h270f
`define FUNC_COUNT        13

// ----------------------------------------------------------------------------
// Speed step limits and coarse increments
// ----------------------------------------------------------------------------
`define MAX_STEP_14       7'h0e
`define MAX_STEP_27       7'h1b
`define MAX_STEP_28       7'h1c
`define MAX_STEP_128      7'h7e
`define COARSE_14         7'h05
`define COARSE_28         7'h08
`define COARSE_128        7'h10

// ----------------------------------------------------------------------------
// Key positions in the conditioned key vector
// ----------------------------------------------------------------------------
`define KEY_FINE_DN       0
`define KEY_FINE_UP       1
`define KEY_COARSE_DN     2
`define KEY_COARSE_UP     3
`define KEY_ENTER         4
`define KEY_DIRECTION     5
`define KEY_EMERGENCY     6
`define KEY_FUNC0         7
`define KEY_COUNT         20
`define KEY_REPEAT        4

`endif

// >>> hdl/throttle_pkg.sv
package throttle_pkg;

   typedef enum logic [1:0] {
      MODE_14  = 2'b00,
      MODE_27  = 2'b01,
      MODE_28  = 2'b10,
      MODE_128 = 2'b11
   } step_mode_t;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

endpackage

// >>> hdl/key_if.sv
`timescale 1ns/1ps

interface key_if #(
   parameter int N = 20
);
   logic [N-1:0] level;
   logic [N-1:0] press;
   logic [N-1:0] step;

   modport src (output level, output press, output step);
   modport dst (input level, input press, input step);
endinterface

// >>> hdl/key_conditioner.sv
`timescale 1ns/1ps

module key_conditioner #(
   parameter int N_KEYS        = 20,
   parameter int N_REPEAT      = 4,
   parameter int REPEAT_CYCLES = 12500000
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic [N_KEYS-1:0] key_raw,
   key_if.src                     keys
);

   if (N_REPEAT > N_KEYS || REPEAT_CYCLES < 2) begin : g_bad
      $error("key_conditioner: unsupported parameters");
   end

   genvar i;
   for (i = 0; i < N_KEYS; i++) begin : g_key
      logic        s1, s2, s3;
      logic        lvl;
      logic        prs;
      logic [31:0] cnt;
      logic        rpt;
      wire         agree = (s2 == s3);

      // Pins are asynchronous; the level changes only once two stages agree.
      always_ff @(posedge sys_clk) begin
         if (!resetn) begin
            s1  <= 1'b0;
            s2  <= 1'b0;
            s3  <= 1'b0;
            lvl <= 1'b0;
            prs <= 1'b0;
         end else begin
            s1  <= key_raw[i];
            s2  <= s1;
            s3  <= s2;
            prs <= agree && s3 && !lvl;
            if (agree) begin
               lvl <= s3;
            end
         end
      end

      // Held speed keys fire a step every repeat period after the press.
      if (i < N_REPEAT) begin : g_rep
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               cnt <= 32'h0;
               rpt <= 1'b0;
            end else if (!lvl) begin
               cnt <= 32'h0;
               rpt <= 1'b0;
            end else if (cnt == 32'(REPEAT_CYCLES - 1)) begin
               cnt <= 32'h0;
               rpt <= 1'b1;
            end else begin
               cnt <= cnt + 32'h1;
               rpt <= 1'b0;
            end
         end
      end else begin : g_norep
         assign cnt = 32'h0;
         assign rpt = 1'b0;
      end

      assign keys.level[i] = lvl;
      assign keys.press[i] = prs;
      assign keys.step[i]  = prs | rpt;
   end

endmodule

// >>> hdl/bin_to_bcd4.sv
`timescale 1ns/1ps

module bin_to_bcd4 (
   input  wire logic [13:0] bin,
   output logic      [15:0] bcd
);

   // Shift-and-add-three; the input never exceeds four decimal digits.
   always_comb begin
      logic [29:0] sh;
      sh = {16'h0, bin};
      for (int b = 0; b < 14; b++) begin
         for (int d = 0; d < 4; d++) begin
            if (sh[14 + 4*d +: 4] > 4'h4) begin
               sh[14 + 4*d +: 4] = sh[14 + 4*d +: 4] + 4'h3;
            end
         end
         sh = {sh[28:0], 1'b0};
      end
      bcd = sh[29:14];
   end

endmodule

// >>> sim/throttle_props.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port-level checks of the throttle block
// ----------------------------------------------------------------------------
module throttle_props (
   input wire logic                     sys_clk,
   input wire logic                     resetn,
   input wire logic [4:0]               avs_address,
   input wire logic                     avs_read,
   input wire logic [31:0]              avs_readdata,
   input wire logic                     avs_waitrequest,
   input wire logic [6:0]               speed_step,
   input wire logic                     forward,
   input wire logic                     show_speed,
   input wire logic                     immediate_stop,
   input wire logic                     emergency_stop,
   input wire logic [13:0]              loco_address,
   input wire logic                     conventional_loco,
   input wire throttle_pkg::step_mode_t step_mode
);
   import throttle_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_top_step: assert property (step_mode == MODE_128 |-> speed_step <= 7'h7e)
      else $error("speed step above the top of the mode");
   a_stop_zero: assert property (immediate_stop |-> speed_step == 7'h00)
      else $error("direct stop left the loco moving");
   a_estop_still: assert property ($past(emergency_stop) && emergency_stop |->
         speed_step == 7'h00)
      else $error("loco moves under layout stop");
   // A mode change never clamps the step; the bound is skipped in the cycle that sees the mode change and whenever the step is zero.
   a_speed_jump: assert property (speed_step != 7'h00 && $stable(step_mode) |->
         {1'b0, speed_step} <= {1'b0, $past(speed_step)} + 8'h10 &&
         {1'b0, speed_step} + 8'h10 >= {1'b0, $past(speed_step)})
      else $error("speed moved by more than a coarse step");
   a_zero_view: assert property (speed_step == 7'h00 && $past(speed_step) != 7'h00 |->
         ##[0:1] !show_speed)
      else $error("address view not restored at standstill");
   a_dir_still: assert property ($changed(forward) |-> $past(speed_step) == 7'h00)
      else $error("direction changed while moving");
   a_conv_flag: assert property (conventional_loco == ($past(loco_address) == 14'h0000))
      else $error("conventional flag does not follow address");
   a_addr_range: assert property (loco_address <= 14'h270f)
      else $error("address beyond the accepted range");
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");
   a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read) &&
         $past(avs_address[1:0]) != 2'b00 |-> avs_readdata == 32'h0)
      else $error("unmapped read returned data");
endmodule

bind throttle_speed_direction_control throttle_props u_props (
   .sys_clk, .resetn, .avs_address, .avs_read, .avs_readdata, .avs_waitrequest, .speed_step,
   .forward, .show_speed, .immediate_stop, .emergency_stop, .loco_address, .conventional_loco,
   .step_mode
);

// >>> sim/keypad_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Operator keypad: holds one key for a set number of cycles
// ----------------------------------------------------------------------------
module keypad_model (
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic [4:0]  idx,
   input  wire logic [15:0] hold,
   output logic      [19:0] keys,
   output logic             busy
);
   logic [15:0] left = 16'h0000;

   // Released keys read low, so no key is ever left floating between presses.
   initial keys = 20'h00000;
   assign busy = left != 16'h0000;

   always @(posedge sys_clk) begin
      if (go) begin
         keys <= 20'h00001 << idx;
         left <= hold;
      end else if (left > 16'h0001) begin
         left <= left - 16'h0001;
      end else begin
         keys <= 20'h00000;
         left <= 16'h0000;
      end
   end
endmodule

// >>> sim/tb_throttle_speed_direction_control.sv
`timescale 1ns/1ps
`include "throttle_map.svh"

// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module tb_throttle_speed_direction_control;
   import throttle_pkg::*;

   logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest, irq, go, busy;
   logic        forward, show_speed, immediate_stop, emergency_stop, conventional_loco;
   logic [4:0]  avs_address, idx;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] hold, address_digits;
   logic [19:0] keys;
   logic [6:0]  speed_step;
   logic [13:0] loco_address;
   logic [12:0] function_active;
   step_mode_t  step_mode;
   int          miscompares, cmp_count, stops;
   logic [6:0]  inc [4] = '{7'h05, 7'h08, 7'h08, 7'h10};

   throttle_speed_direction_control #(.REPEAT_CYCLES(20)) dut (
      .sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq,
      .key_fine_down(keys[0]), .key_fine_up(keys[1]), .key_coarse_down(keys[2]),
      .key_coarse_up(keys[3]), .key_enter(keys[4]), .key_direction(keys[5]),
      .key_emergency(keys[6]), .key_function(keys[19:7]), .speed_step, .forward,
      .show_speed, .immediate_stop, .emergency_stop, .loco_address, .conventional_loco,
      .address_digits, .step_mode, .function_active
   );

   keypad_model pad (.sys_clk, .go, .idx, .hold, .keys, .busy);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // The stop pulse lasts one cycle, so it is counted rather than looked at.
   always @(posedge sys_clk) begin
      if (immediate_stop === 1'b1)
         stops++;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // The request stays up until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      chk(avs_waitrequest, 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // One more edge lets the written register settle before callers look.
      @(posedge sys_clk);
   endtask

   task automatic start(input logic [4:0] k, input logic [15:0] h);
      @(posedge sys_clk);
      idx <= k;
      hold <= h;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
   endtask

   task automatic finish;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (busy !== 1'b0 && n < 4000);
      repeat (12) @(posedge sys_clk);
   endtask

   task automatic press(input logic [4:0] k, input logic [15:0] h);
      start(k, h);
      finish;
   endtask

   task automatic t_reset;
      repeat (2) @(posedge sys_clk);
      chk(address_digits, 16'h0003);
      chk(forward, 1'b1);
      bus(1'b0, `REG_CTRL, 32'h0);
      chk(rd, 32'h2);
   endtask

   task automatic t_fine;
      press(`KEY_FINE_UP, 8);
      chk(speed_step, 7'h01);
      chk(show_speed, 1'b1);
      press(`KEY_FINE_UP, 8);
      press(`KEY_FINE_DN, 8);
      chk(speed_step, 7'h01);
      press(`KEY_FINE_DN, 8);
      chk(show_speed, 1'b0);
      press(`KEY_FINE_DN, 8);
      chk(speed_step, 7'h00);
   endtask

   task automatic t_coarse;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, `REG_CTRL, m);
         chk(step_mode, m);
         press(`KEY_COARSE_UP, 8);
         chk(speed_step, inc[m]);
         press(`KEY_COARSE_DN, 8);
         chk(speed_step, 7'h00);
      end
      bus(1'b1, `REG_CTRL, 32'h0);
      repeat (3) press(`KEY_COARSE_UP, 8);
      chk(speed_step, 7'h0e);
      press(`KEY_FINE_DN, 400);
      chk(speed_step, 7'h00);
   endtask

   task automatic t_repeat;
      bus(1'b1, `REG_CTRL, 32'h3);
      press(`KEY_COARSE_UP, 300);
      chk(speed_step, 7'h7e);
   endtask

   task automatic t_dir;
      press(`KEY_DIRECTION, 8);
      chk(speed_step, 7'h00);
      chk(stops, 1);
      chk(forward, 1'b1);
      press(`KEY_DIRECTION, 8);
      chk(forward, 1'b0);
      press(`KEY_DIRECTION, 8);
      chk(forward, 1'b1);
   endtask

   task automatic t_enter;
      press(`KEY_ENTER, 8);
      chk(show_speed, 1'b1);
      press(`KEY_ENTER, 8);
      chk(show_speed, 1'b0);
   endtask

   task automatic t_estop;
      press(`KEY_FINE_UP, 8);
      press(`KEY_EMERGENCY, 8);
      chk(emergency_stop, 1'b1);
      press(`KEY_FINE_UP, 8);
      chk(speed_step, 7'h00);
      press(`KEY_EMERGENCY, 8);
      chk(emergency_stop, 1'b0);
   endtask

   task automatic t_addr;
      bus(1'b1, `REG_IRQ_STATUS, 32'hf);
      bus(1'b1, `REG_IRQ_MASK, 32'h0);
      bus(1'b1, `REG_ADDR, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk(conventional_loco, 1'b1);
      bus(1'b1, `REG_ADDR, 32'h270f);
      repeat (2) @(posedge sys_clk);
      chk(address_digits, 16'h9999);
      bus(1'b1, `REG_ADDR, 32'h2710);
      bus(1'b0, `REG_ADDR, 32'h0);
      chk(rd, 32'h270f);
      chk(loco_address, 14'h270f);
      bus(1'b0, `REG_IRQ_STATUS, 32'h0);
      chk(rd[3], 1'b1);
      chk(irq, 1'b0);
      bus(1'b1, `REG_IRQ_MASK, 32'h8);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b1);
      bus(1'b1, `REG_IRQ_STATUS, 32'h8);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
      bus(1'b0, 5'h02, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_func;
      bus(1'b1, `REG_FUNC_MODE, 32'h1);
      start(`KEY_FUNC0, 40);
      repeat (20) @(posedge sys_clk);
      chk(function_active[0], 1'b1);
      finish;
      chk(function_active[0], 1'b0);
      press(5'(`KEY_FUNC0 + 1), 8);
      chk(function_active[1], 1'b1);
      press(5'(`KEY_FUNC0 + 1), 8);
      chk(function_active[1], 1'b0);
      press(5'(`KEY_FUNC0 + 12), 8);
      chk(function_active[12], 1'b1);
   endtask

   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      go = 1'b0;
      idx = 5'h00;
      hold = 16'h0000;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset;
      t_fine;
      t_coarse;
      t_repeat;
      t_dir;
      t_enter;
      t_estop;
      t_addr;
      t_func;
      wrap_up;
   end

   // The longest held key is 400 cycles and the whole run about 1500; this margin is generous.
   initial begin
      repeat (40000) @(posedge sys_clk);
      miscompares++;
      wrap_up;
   end
endmodule
